// ==== rtl/emseq_pkg.sv ====
// shared constants and types of the external bus cycle sequencer
package emseq_pkg;

    typedef enum logic [2:0] {
        ST_IDLE = 3'h0,
        ST_ALE  = 3'h1,
        ST_ALEX = 3'h5,
        ST_STB  = 3'h3,
        ST_DATA = 3'h2,
        ST_HIT  = 3'h4
    } emseq_state_t;

    typedef enum logic [1:0] {
        KIND_CODE = 2'h0,
        KIND_RD   = 2'h1,
        KIND_WR   = 2'h2
    } emseq_kind_t;

    // field positions inside the two configuration bytes
    localparam int unsigned CFG0_PAGE_N_BIT = 1;
    localparam int unsigned CFG0_RGN_LSB    = 2;
    localparam int unsigned CFG0_LATCH_PULSE_EXTEND_N_N_BIT = 4;
    localparam int unsigned CFG0_WSA_LSB    = 5;
    localparam int unsigned CFG1_WSB_LSB    = 3;

    localparam logic [1:0] RGN_LIMITED  = 2'h3;
    localparam logic [7:0] RGN_HIGH_MIN = 8'hfe;
    localparam logic [7:0] RGN_WSB      = 8'h01;
    localparam logic [7:0] PAGE_LAST_LO = 8'hff;
    localparam logic [7:0] PAGE_FIRST_LO = 8'h00;
    localparam logic [7:0] DATA_RST     = 8'h00;
    localparam logic [1:0] WAIT_NONE    = 2'h0;
    localparam logic [1:0] WAIT_STEP    = 2'h1;

endpackage

// ==== rtl/emseq_cfg_if.sv ====
// reset-time configuration passed from the capture module to the sequencer
`timescale 1ns/1ps
interface emseq_cfg_if;
    logic       page_mode;
    logic       latch_pulse_extend_n;
    logic [1:0] region_sel;
    logic [1:0] wait_a;
    logic [1:0] wait_b;
    logic       ready;

    modport src (output page_mode, latch_pulse_extend_n, region_sel, wait_a, wait_b, ready);
    modport snk (input  page_mode, latch_pulse_extend_n, region_sel, wait_a, wait_b, ready);
endinterface

// ==== rtl/emseq_cfg.sv ====
// captures the configuration bytes once after reset release
`timescale 1ns/1ps
module emseq_cfg (
    input  logic       clock_i,
    input  logic       rstn_i,
    input  logic       ce_i,
    input  logic [7:0] byte0_i,
    input  logic [7:0] byte1_i,
    emseq_cfg_if.src   cfg
);
    logic       loaded_q;
    logic       page_q;
    logic       latch_pulse_extend_n_q;
    logic [1:0] rgn_q;
    logic [1:0] wsa_q;
    logic [1:0] wsb_q;

    // loaded once, then frozen until the next reset
    always_ff @(posedge clock_i) begin
        if (!rstn_i) begin
            loaded_q <= 1'b0;
            page_q   <= 1'b0;
            latch_pulse_extend_n_q   <= 1'b0;
            rgn_q    <= 2'h0;
            wsa_q    <= 2'h0;
            wsb_q    <= 2'h0;
        end else if (ce_i && !loaded_q) begin
            loaded_q <= 1'b1;
            page_q   <= ~byte0_i[emseq_pkg::CFG0_PAGE_N_BIT];
            latch_pulse_extend_n_q   <= ~byte0_i[emseq_pkg::CFG0_LATCH_PULSE_EXTEND_N_N_BIT];
            rgn_q    <= byte0_i[emseq_pkg::CFG0_RGN_LSB +: 2];
            wsa_q    <= ~byte0_i[emseq_pkg::CFG0_WSA_LSB +: 2];
            wsb_q    <= ~byte1_i[emseq_pkg::CFG1_WSB_LSB +: 2];
        end
    end

    assign cfg.ready      = loaded_q;
    assign cfg.page_mode  = page_q;
    assign cfg.latch_pulse_extend_n       = latch_pulse_extend_n_q;
    assign cfg.region_sel = rgn_q;
    assign cfg.wait_a     = wsa_q;
    assign cfg.wait_b     = wsb_q;
endmodule

// ==== rtl/emseq_page.sv ====
// remembers the open 256-byte code page and flags page hits
`timescale 1ns/1ps
module emseq_page (
    input  logic        clock_i,
    input  logic        rstn_i,
    input  logic        ce_i,
    input  logic        page_mode_i,
    input  logic        fetch_i,
    input  logic        seq_i,
    input  logic [15:0] addr_i,
    input  logic        invalidate_i,
    output logic        hit_o,
    output logic        valid_o
);
    logic       valid_q;
    logic [7:0] page_q;
    logic [7:0] last_lo_q;
    logic       rollover;

    assign rollover = (last_lo_q == emseq_pkg::PAGE_LAST_LO)
                    && (addr_i[7:0] == emseq_pkg::PAGE_FIRST_LO);
    // branch, rollover or a new page all make a miss
    assign hit_o   = page_mode_i && valid_q && seq_i && !rollover
                   && (addr_i[15:8] == page_q);
    assign valid_o = valid_q;

    always_ff @(posedge clock_i) begin
        if (!rstn_i) begin
            valid_q   <= 1'b0;
            page_q    <= emseq_pkg::DATA_RST;
            last_lo_q <= emseq_pkg::DATA_RST;
        end else if (ce_i) begin
            if (invalidate_i) begin
                valid_q <= 1'b0;
            end else if (fetch_i) begin
                last_lo_q <= addr_i[7:0];
                if (!hit_o) begin
                    page_q  <= addr_i[15:8];
                    valid_q <= 1'b1;
                end
            end
        end
    end
endmodule

// ==== rtl/emseq_top.sv ====
// external memory bus cycle sequencer: code fetch, data read, data write
`timescale 1ns/1ps
module emseq_top #(
    parameter int unsigned ADDR_W = 16,
    parameter int unsigned DATA_W = 8
) (
    input  logic              clock_i,
    input  logic              rstn_i,
    input  logic              ce_i,
    input  logic              idle_mode_i,
    input  logic              powerdown_mode_i,
    input  logic [7:0]        user_config_byte_zero_i,
    input  logic [7:0]        user_config_byte_one_i,
    input  logic              req_valid_i,
    output logic              req_ready_o,
    input  logic [1:0]        req_kind_i,
    input  logic              req_internal_i,
    input  logic              req_seq_i,
    input  logic [7:0]        req_region_i,
    input  logic [ADDR_W-1:0] req_addr_i,
    input  logic [DATA_W-1:0] req_wdata_i,
    output logic              rsp_valid_o,
    output logic [DATA_W-1:0] rsp_data_o,
    input  logic [DATA_W-1:0] port0_i,
    output logic [DATA_W-1:0] port0_o,
    output logic              port0_oe_o,
    input  logic [DATA_W-1:0] port2_i,
    output logic [DATA_W-1:0] port2_o,
    output logic              port2_oe_o,
    output logic              addr_latch_o,
    output logic              program_store_strobe_n_o,
    output logic              read_strobe_n_o,
    output logic              write_strobe_n_o,
    output logic              page_mode_o
);
    generate
        if (ADDR_W != 16 || DATA_W != 8) begin : g_bad_width
            $error("emseq_top serves only a 16-bit address, 8-bit data");
        end
    endgenerate

    emseq_cfg_if cfg ();

    emseq_cfg u_cfg (
        .clock_i (clock_i),
        .rstn_i  (rstn_i),
        .ce_i    (ce_i),
        .byte0_i (user_config_byte_zero_i),
        .byte1_i (user_config_byte_one_i),
        .cfg     (cfg)
    );

    emseq_pkg::emseq_state_t st_q;
    emseq_pkg::emseq_kind_t  kind_q;
    logic [ADDR_W-1:0] addr_q;
    logic [DATA_W-1:0] wdata_q;
    logic [7:0]        region_q;
    logic [1:0]        wcnt_q;
    logic [1:0]        wsel_q;
    logic [1:0]        stb_len_q;
    logic              rsp_valid_q;
    logic [DATA_W-1:0] rsp_data_q;

    logic              take;
    logic              ext_take;
    logic              code_req;
    logic              pg_hit;
    logic              pg_valid;
    logic              pg_inval;
    logic [1:0]        wait_sel;
    logic              pm;
    logic              ale_st;
    logic              data_st;
    logic              is_wr;
    logic              wr_allowed;
    logic [DATA_W-1:0] cap_port;

    assign pm       = cfg.page_mode;
    assign code_req = (req_kind_i == emseq_pkg::KIND_CODE);
    // the bus stays quiet in idle and powerdown
    assign req_ready_o = cfg.ready && (st_q == emseq_pkg::ST_IDLE)
                       && !idle_mode_i && !powerdown_mode_i;
    assign take     = ce_i && req_valid_i && req_ready_o;
    assign ext_take = take && !req_internal_i;
    // any external data cycle or low-power mode closes the page
    assign pg_inval = idle_mode_i || powerdown_mode_i
                    || (ext_take && !code_req);

    emseq_page u_page (
        .clock_i      (clock_i),
        .rstn_i       (rstn_i),
        .ce_i         (ce_i),
        .page_mode_i  (pm),
        .fetch_i      (ext_take && code_req),
        .seq_i        (req_seq_i),
        .addr_i       (req_addr_i),
        .invalidate_i (pg_inval),
        .hit_o        (pg_hit),
        .valid_o      (pg_valid)
    );

    // wait set b covers one region only; all others use set a
    assign wait_sel = (req_region_i == emseq_pkg::RGN_WSB) ? cfg.wait_b
                                                           : cfg.wait_a;

    // cycle sequencing, one state per enabled clock
    always_ff @(posedge clock_i) begin
        if (!rstn_i) begin
            st_q <= emseq_pkg::ST_IDLE;
        end else if (ce_i) begin
            case (st_q)
                emseq_pkg::ST_IDLE: begin
                    if (ext_take) begin
                        if (code_req && pg_hit) begin
                            st_q <= emseq_pkg::ST_HIT;
                        end else begin
                            st_q <= emseq_pkg::ST_ALE;
                        end
                    end
                end
                emseq_pkg::ST_ALE: begin
                    if (cfg.latch_pulse_extend_n) begin
                        st_q <= emseq_pkg::ST_ALEX;
                    end else begin
                        st_q <= emseq_pkg::ST_STB;
                    end
                end
                emseq_pkg::ST_ALEX: begin
                    st_q <= emseq_pkg::ST_STB;
                end
                emseq_pkg::ST_STB: begin
                    if (wcnt_q != emseq_pkg::WAIT_NONE) begin
                        st_q <= emseq_pkg::ST_STB;
                    end else if (kind_q == emseq_pkg::KIND_CODE) begin
                        st_q <= emseq_pkg::ST_IDLE;
                    end else begin
                        st_q <= emseq_pkg::ST_DATA;
                    end
                end
                emseq_pkg::ST_DATA: begin
                    st_q <= emseq_pkg::ST_IDLE;
                end
                emseq_pkg::ST_HIT: begin
                    st_q <= emseq_pkg::ST_IDLE;
                end
                default: begin
                    st_q <= emseq_pkg::ST_IDLE;
                end
            endcase
        end
    end

    // request fields held for the whole cycle
    always_ff @(posedge clock_i) begin
        if (!rstn_i) begin
            kind_q   <= emseq_pkg::KIND_CODE;
            addr_q   <= '0;
            wdata_q  <= emseq_pkg::DATA_RST;
            region_q <= emseq_pkg::DATA_RST;
            wsel_q   <= emseq_pkg::WAIT_NONE;
        end else if (ext_take) begin
            kind_q   <= emseq_pkg::emseq_kind_t'(req_kind_i);
            addr_q   <= req_addr_i;
            wdata_q  <= req_wdata_i;
            region_q <= req_region_i;
            wsel_q   <= wait_sel;
        end
    end

    // remaining strobe wait states
    always_ff @(posedge clock_i) begin
        if (!rstn_i) begin
            wcnt_q <= emseq_pkg::WAIT_NONE;
        end else if (ce_i) begin
            if (ext_take) begin
                wcnt_q <= wait_sel;
            end else if (st_q == emseq_pkg::ST_STB
                         && wcnt_q != emseq_pkg::WAIT_NONE) begin
                wcnt_q <= wcnt_q - emseq_pkg::WAIT_STEP;
            end
        end
    end

    // strobe length seen so far, checked against the chosen wait count
    always_ff @(posedge clock_i) begin
        if (!rstn_i) begin
            stb_len_q <= emseq_pkg::WAIT_NONE;
        end else if (ce_i) begin
            if (st_q == emseq_pkg::ST_STB) begin
                stb_len_q <= stb_len_q + emseq_pkg::WAIT_STEP;
            end else begin
                stb_len_q <= emseq_pkg::WAIT_NONE;
            end
        end
    end

    assign cap_port = pm ? port2_i : port0_i;

    // answers: code at end of strobe, read data one state later
    always_ff @(posedge clock_i) begin
        if (!rstn_i) begin
            rsp_valid_q <= 1'b0;
            rsp_data_q  <= emseq_pkg::DATA_RST;
        end else if (ce_i) begin
            rsp_valid_q <= 1'b0;
            if (take && req_internal_i) begin
                rsp_valid_q <= 1'b1;
            end else if (st_q == emseq_pkg::ST_HIT) begin
                rsp_valid_q <= 1'b1;
                rsp_data_q  <= port2_i;
            end else if (st_q == emseq_pkg::ST_STB
                         && wcnt_q == emseq_pkg::WAIT_NONE
                         && kind_q == emseq_pkg::KIND_CODE) begin
                rsp_valid_q <= 1'b1;
                rsp_data_q  <= cap_port;
            end else if (st_q == emseq_pkg::ST_DATA) begin
                rsp_valid_q <= 1'b1;
            end
            // memory lets go of the bus once the read strobe rises
            if (st_q == emseq_pkg::ST_STB && wcnt_q == emseq_pkg::WAIT_NONE
                && kind_q == emseq_pkg::KIND_RD) begin
                rsp_data_q <= cap_port;
            end
        end
    end

    assign rsp_valid_o = rsp_valid_q;
    assign rsp_data_o  = rsp_data_q;
    assign page_mode_o = pm;

    // pin drive
    assign ale_st  = (st_q == emseq_pkg::ST_ALE)
                   || (st_q == emseq_pkg::ST_ALEX);
    assign data_st = (st_q == emseq_pkg::ST_STB)
                   || (st_q == emseq_pkg::ST_DATA);
    assign is_wr   = (kind_q == emseq_pkg::KIND_WR);
    assign wr_allowed = !(cfg.region_sel == emseq_pkg::RGN_LIMITED
                        && region_q >= emseq_pkg::RGN_HIGH_MIN);

    assign addr_latch_o = ale_st;
    assign program_store_strobe_n_o = !((st_q == emseq_pkg::ST_STB
                        && kind_q == emseq_pkg::KIND_CODE)
                        || st_q == emseq_pkg::ST_HIT);
    assign read_strobe_n_o  = !(st_q == emseq_pkg::ST_STB
                              && kind_q == emseq_pkg::KIND_RD);
    // strobe is low in the strobe state only; the data state after it gives the bus recovery time
    assign write_strobe_n_o = !(st_q == emseq_pkg::ST_STB
                              && is_wr && wr_allowed);

    // nonpage: port 0 muxed, port 2 steady; page mode swaps the roles
    always_comb begin
        if (!pm) begin
            port0_oe_o = ale_st || (data_st && is_wr);
            port0_o    = ale_st ? addr_q[7:0] : wdata_q;
            port2_oe_o = (st_q != emseq_pkg::ST_IDLE);
            port2_o    = addr_q[15:8];
        end else begin
            port0_oe_o = (st_q != emseq_pkg::ST_IDLE);
            port0_o    = addr_q[7:0];
            port2_oe_o = ale_st || (data_st && is_wr);
            port2_o    = ale_st ? addr_q[15:8] : wdata_q;
        end
    end

    default clocking cb @(posedge clock_i iff ce_i);
    endclocking
    default disable iff (!rstn_i);

    sequence s_strobe_code;
        (st_q == emseq_pkg::ST_STB) && !program_store_strobe_n_o;
    endsequence
    sequence s_code_done;
        (st_q == emseq_pkg::ST_IDLE) && rsp_valid_o;
    endsequence
    sequence s_read_steps;
        !read_strobe_n_o ##1 (st_q == emseq_pkg::ST_DATA && read_strobe_n_o)
        ##1 rsp_valid_o;
    endsequence

    chk_idle_quiet: assert property (
        st_q == emseq_pkg::ST_IDLE |-> !addr_latch_o
        && program_store_strobe_n_o && read_strobe_n_o
        && write_strobe_n_o && !port0_oe_o && !port2_oe_o)
        else $error("bus active while idle");

    chk_nonpage_high: assert property (
        !pm && st_q != emseq_pkg::ST_IDLE
        |-> port2_oe_o && port2_o == addr_q[15:8])
        else $error("upper address not held on port 2");

    chk_code_two: assert property (
        (st_q == emseq_pkg::ST_ALE && kind_q == emseq_pkg::KIND_CODE
         && !cfg.latch_pulse_extend_n && wcnt_q == emseq_pkg::WAIT_NONE)
        |=> s_strobe_code ##1 s_code_done)
        else $error("code fetch not two states");

    chk_read_three: assert property (
        (st_q == emseq_pkg::ST_ALE && kind_q == emseq_pkg::KIND_RD
         && !cfg.latch_pulse_extend_n && wcnt_q == emseq_pkg::WAIT_NONE)
        |=> s_read_steps)
        else $error("data read not three states");

    chk_write_recover: assert property (
        st_q == emseq_pkg::ST_DATA && is_wr |-> write_strobe_n_o
        && (pm ? (port2_oe_o && port2_o == wdata_q)
               : (port0_oe_o && port0_o == wdata_q)))
        else $error("write recovery state wrong");

    chk_write_region: assert property (
        st_q == emseq_pkg::ST_STB && is_wr
        |-> write_strobe_n_o == !wr_allowed)
        else $error("write strobe region gating wrong");

    chk_page_low: assert property (
        pm && st_q != emseq_pkg::ST_IDLE
        |-> port0_oe_o && port0_o == addr_q[7:0])
        else $error("low address not held on port 0");

    chk_hit_single: assert property (
        st_q == emseq_pkg::ST_HIT |-> !addr_latch_o
        && !program_store_strobe_n_o && !port2_oe_o && pg_valid
        ##1 (st_q == emseq_pkg::ST_IDLE && rsp_valid_o))
        else $error("page hit cycle wrong");

    chk_strobe_length: assert property (
        st_q != emseq_pkg::ST_STB && $past(st_q) == emseq_pkg::ST_STB
        |-> $past(stb_len_q) == wsel_q)
        else $error("strobe length differs from wait count");

    chk_ale_extend: assert property (
        st_q == emseq_pkg::ST_ALE && cfg.latch_pulse_extend_n
        |=> addr_latch_o ##1 (st_q == emseq_pkg::ST_STB))
        else $error("latch pulse not extended");

    chk_cfg_fixed: assert property (
        cfg.ready && $past(cfg.ready) |-> $stable(cfg.wait_a)
        && $stable(cfg.wait_b) && $stable(cfg.latch_pulse_extend_n) && $stable(pm))
        else $error("configuration changed after load");
endmodule

// ==== tb/emseq_mem.sv ====
// external memory with address latch, answering on the data port
`timescale 1ns/1ps
module emseq_mem (
    input  logic        clock_i,
    input  logic        clr_i,
    input  logic        page_i,
    input  logic        ale_i,
    input  logic        prog_n_i,
    input  logic        read_n_i,
    input  logic        write_n_i,
    input  logic [7:0]  bus0_i,
    input  logic [7:0]  bus2_i,
    output logic [7:0]  bus0_o,
    output logic [7:0]  bus2_o,
    output logic [3:0]  lat_o,
    output logic [3:0]  stb_o,
    output logic [15:0] addr_o,
    output logic [7:0]  wdata_o
);
    logic [7:0] hi_q;
    logic [7:0] lo_q;
    logic [7:0] last_q;
    logic [7:0] lo;
    logic [7:0] rdata;
    logic       rd_on;

    assign rd_on  = !prog_n_i || !read_n_i;
    assign lo     = page_i ? bus0_i : lo_q;
    assign rdata  = hi_q ^ lo ^ 8'h3c;
    // released lines show the inverse of the last value, never a held copy
    assign bus0_o = (rd_on && !page_i) ? rdata : ~last_q;
    assign bus2_o = (rd_on && page_i) ? rdata : ~last_q;
    assign addr_o = {hi_q, lo_q};

    always_ff @(posedge clock_i) begin
        if (ale_i) begin
            hi_q <= bus2_i;
        end
        if (ale_i || (page_i && (rd_on || !write_n_i))) begin
            lo_q <= bus0_i;
        end
        if (rd_on) begin
            last_q <= rdata;
        end
        if (!write_n_i) begin
            wdata_o <= page_i ? bus2_i : bus0_i;
        end
        lat_o <= clr_i ? 4'h0 : lat_o + 4'(ale_i);
        stb_o <= clr_i ? 4'h0 : stb_o + 4'(rd_on || !write_n_i);
    end
endmodule

// ==== tb/ext_mem_bus_cycle_sequencer_tb.sv ====
// self-checking bench: random and corner bus accesses across configs
`timescale 1ns/1ps
module ext_mem_bus_cycle_sequencer_tb;
    logic        clk, rstn, idle, pd, vld, intl, seq, clr, page, latch_pulse_extend_n, blk;
    logic        rdy, rsv, p0e, p2e, ale, psn, rdn, wrn, pmo, open_v, ce;
    logic [1:0]  kind, wa, wb, rsel;
    logic [7:0]  b0, b1, rgn, wd, p0i, p2i, p0o, p2o, rdat, mwd, open_hi;
    logic [15:0] adr, maddr;
    logic [3:0]  lat, stb;
    int          failures, checks_done;

    emseq_top emseq_top_i (.clock_i(clk), .rstn_i(rstn), .ce_i(ce),
        .idle_mode_i(idle), .powerdown_mode_i(pd),
        .user_config_byte_zero_i(b0), .user_config_byte_one_i(b1),
        .req_valid_i(vld), .req_ready_o(rdy), .req_kind_i(kind),
        .req_internal_i(intl), .req_seq_i(seq), .req_region_i(rgn),
        .req_addr_i(adr), .req_wdata_i(wd), .rsp_valid_o(rsv),
        .rsp_data_o(rdat), .port0_i(p0i), .port0_o(p0o), .port0_oe_o(p0e),
        .port2_i(p2i), .port2_o(p2o), .port2_oe_o(p2e),
        .addr_latch_o(ale), .program_store_strobe_n_o(psn),
        .read_strobe_n_o(rdn), .write_strobe_n_o(wrn), .page_mode_o(pmo));

    emseq_mem emseq_mem_i (.clock_i(clk), .clr_i(clr), .page_i(page),
        .ale_i(ale), .prog_n_i(psn), .read_n_i(rdn), .write_n_i(wrn),
        .bus0_i(p0o), .bus2_i(p2o), .bus0_o(p0i), .bus2_o(p2i),
        .lat_o(lat), .stb_o(stb), .addr_o(maddr), .wdata_o(mwd));

    initial begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks_done++;
        if (got !== exp) begin
            failures++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic print_verdict();
        $display("checks=%0d failures=%0d", checks_done, failures);
        if (failures == 0 && checks_done > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask

    task automatic hang();
        failures++;
        print_verdict();
    endtask

    task automatic setup(input logic [2:0] i);
        {page, latch_pulse_extend_n, wa, wb, rsel} = {i[0], i[1], i[2:1], ~i[1:0], i[1:0]};
        @(posedge clk);
        rstn <= 1'b0;
        clr <= 1'b1;
        b0 <= {1'b0, ~wa, ~latch_pulse_extend_n, rsel, ~page, 1'b0};
        b1 <= {3'h0, ~wb, 3'h0};
        repeat (2) @(posedge clk);
        rstn <= 1'b1;
        clr <= 1'b0;
        open_v = 1'b0;
        repeat (3) @(posedge clk);
        // later traffic must still follow the bytes seen at reset
        b0 <= ~b0;
        b1 <= ~b1;
        chk(32'(pmo), 32'(page));
        chk(32'({lat, stb}), 0);
    endtask

    task automatic access(input logic [1:0] k, input logic in, input logic sq,
                          input logic [7:0] rg, input logic [15:0] a);
        logic       hit, fz;
        logic [1:0] w;
        int         n, e, el, es;
        hit = page && k == 2'h0 && !in && sq && open_v && open_hi == a[15:8];
        w = (rg == 8'h01) ? wb : wa;
        blk = k == 2'h2 && rsel == 2'h3 && rg >= 8'hfe;
        // two frozen edges right after the take delay the whole cycle
        fz = !in && ($urandom % 8) == 0;
        e = in ? 1 : hit ? 2 : ((k == 2'h0) ? 3 : 4) + latch_pulse_extend_n + w;
        e = e + (fz ? 2 : 0);
        el = (in || hit) ? 0 : 1 + latch_pulse_extend_n + (fz ? 2 : 0);
        es = (in || blk) ? 0 : hit ? (fz ? 3 : 1) : 1 + w;
        @(posedge clk);
        {vld, kind, intl, seq} <= {1'b1, k, in, sq};
        {rgn, adr, clr} <= {rg, a, 1'b1};
        wd <= 8'($urandom);
        n = 0;
        do begin
            @(negedge clk);
            n++;
        end while (rdy !== 1'b1 && n < 50);
        if (rdy !== 1'b1) hang();
        @(posedge clk);
        vld <= 1'b0;
        clr <= 1'b0;
        n = 0;
        if (fz) begin
            ce <= 1'b0;
            repeat (2) @(posedge clk);
            ce <= 1'b1;
            n = 2;
        end
        do begin
            @(negedge clk);
            n++;
        end while (rsv !== 1'b1 && n < 50);
        if (rsv !== 1'b1) hang();
        chk(32'(n), 32'(e));
        chk(32'(lat), 32'(el));
        chk(32'(stb), 32'(es));
        if (!in) chk(32'(maddr), 32'(a));
        if (!in && k != 2'h2) begin
            chk(32'(rdat), 32'(a[15:8] ^ a[7:0] ^ 8'h3c));
        end
        if (!in && !blk && k == 2'h2) chk(32'(mwd), 32'(wd));
        if (!in) begin
            open_v = page && k == 2'h0;
            open_hi = a[15:8];
        end
    endtask

    initial begin
        logic [15:0] pc;
        logic [7:0]  crg;
        logic        br;
        int          r;
        {rstn, idle, pd, vld, intl, seq, clr, kind, rgn, adr, wd} = '0;
        ce = 1'b1;
        {b0, b1, page, latch_pulse_extend_n, wa, wb, rsel, open_v, open_hi, blk} = '0;
        void'($urandom(51409));
        repeat (2) @(posedge clk);
        for (int i = 0; i < 8; i++) begin
            setup(3'(i));
            pc = 16'h12fd;
            crg = {{7{i[2]}}, i[1]};
            access(2'h0, 1'b0, 1'b0, crg, pc);
            br = 1'b0;
            for (int j = 0; j < 30; j++) begin
                r = $urandom % 8;
                if (j == 15) begin
                    @(posedge clk);
                    {pd, idle} <= i[2] ? 2'h2 : 2'h1;
                    repeat (4) @(negedge clk);
                    chk(32'({rdy, ale, psn, rdn, wrn}), 32'h0000_0007);
                    @(posedge clk);
                    {pd, idle} <= 2'h0;
                    open_v = 1'b0;
                end
                if (r < 4 && !br) begin
                    pc = pc + 16'h0001;
                    access(2'h0, 1'b0, 1'b1, crg, pc);
                end else if (r == 4 || br) begin
                    pc = 16'($urandom);
                    access(2'h0, 1'b0, 1'b0, crg, pc);
                    br = 1'b0;
                end else begin
                    access(2'(r == 7 ? $urandom % 3 : r - 4), r == 7, 1'b0,
                           {{7{r[1] & pc[0]}}, r[0]}, 16'($urandom));
                    br = r == 7;
                end
            end
            chk(32'(pmo), 32'(page));
        end
        print_verdict();
    end
endmodule
